// ---- core/rsdc_pkg.sv ----
// constants for the rotor stall detection configuration block
package rsdc_pkg;

	// ------------------------------------------------------------
	// register port and map
	// ------------------------------------------------------------
	localparam int          ADDR_W            = 12;
	localparam int          DATA_W            = 32;
	localparam logic [11:0] OFS_CFG_SHADOW    = 12'h46D;
	localparam logic [11:0] OFS_THR_SHADOW    = 12'h46E;
	localparam logic [11:0] OFS_CFG_NVM       = 12'h4CD;
	localparam logic [11:0] OFS_THR_NVM       = 12'h4CE;
	localparam logic [11:0] OFS_STATUS        = 12'h47F;
	localparam logic [31:0] RESET_VALUE       = 32'h0000_0000;

	// ------------------------------------------------------------
	// configuration register fields
	// ------------------------------------------------------------
	localparam int OL_CMD_LSB        = 4;
	localparam int OL_CMD_W          = 7;
	localparam int OL_TH_LSB         = 11;
	localparam int OL_TH_W           = 6;
	localparam int BEMF_TH_LSB       = 17;
	localparam int BEMF_TH_W         = 4;
	localparam int CRIT_LSB          = 21;
	localparam int CRIT_W            = 3;
	localparam int BLANK_LSB         = 24;
	localparam int BLANK_W           = 2;
	localparam int SYNC_TOUT_LSB     = 26;
	localparam int SYNC_TOUT_W       = 4;
	localparam int FLT_DIS_BIT       = 30;
	localparam int FLT_START_DIS_BIT = 31;

	// ------------------------------------------------------------
	// threshold and password register fields
	// ------------------------------------------------------------
	localparam int DET_TIME_LSB      = 2;
	localparam int DET_TIME_W        = 4;
	localparam int HIGH_TH_LSB       = 6;
	localparam int HIGH_TH_W         = 3;
	localparam int LOW_TH_LSB        = 9;
	localparam int LOW_TH_W          = 3;
	localparam int SPEED_TH_LSB      = 12;
	localparam int SPEED_TH_W        = 4;
	localparam int PASSWORD_LSB      = 16;
	localparam int PASSWORD_W        = 16;
	localparam logic [15:0] PASSWORD_NONE_LO = 16'h0000;
	localparam logic [15:0] PASSWORD_NONE_HI = 16'hFFFF;

	// criteria select bits
	localparam int CRIT_VQ_BIT       = 0;
	localparam int CRIT_FREQ_BIT     = 1;
	localparam int CRIT_BEMF_BIT     = 2;

	// ------------------------------------------------------------
	// scaling: percentages in 1/1024 percent units
	// ------------------------------------------------------------
	localparam int          PCT_W         = 17;
	localparam logic [16:0] OL_CMD_BASE   = 17'h06400; // 25 %
	localparam logic [16:0] OL_CMD_STEP   = 17'h00258; // 0.5859375 %
	localparam logic [16:0] OL_TH_BASE    = 17'h0C800; // 50 %
	localparam logic [16:0] OL_TH_STEP    = 17'h00320; // 0.78125 %
	localparam int          BEMF_SHIFT    = 7;  // 0.78125 % = 1/128
	localparam int          EIGHTH_SHIFT  = 3;  // 12.5 % = 1/8
	localparam int          SPEED_SHIFT   = 10; // 0.09765625 % = 1/1024
	localparam logic [4:0]  HIGH_TH_BASE  = 5'h09; // 100 % + one step

	// ------------------------------------------------------------
	// velocity loop update window exponents
	// ------------------------------------------------------------
	localparam int          CNT_W         = 24;
	localparam logic [4:0]  SYNC_EXP_BASE = 5'h08;
	localparam logic [4:0]  DET_EXP_BASE  = 5'h06;

	typedef enum logic [1:0] {
		RSDC_IDLE,
		RSDC_BLANK,
		RSDC_MONITOR,
		RSDC_STALLED
	} rsdc_state_t;

endpackage : rsdc_pkg

// ---- core/rsdc_vlu_counter.sv ----
// counter of velocity loop updates against a target window
`timescale 1ns/100ps

module rsdc_vlu_counter
(
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	input  wire logic                     clear,
	input  wire logic                     tick,
	input  wire logic [rsdc_pkg::CNT_W-1:0] target,
	output logic                          done
);

	logic [rsdc_pkg::CNT_W-1:0] count;
	logic [rsdc_pkg::CNT_W-1:0] next_count;
	wire                        reached = (count >= target);

	// ------------------------------------------------------------
	// count saturates once the window is reached
	// ------------------------------------------------------------
	assign next_count = clear ? '0 :
		(tick && !reached) ? count + 1'b1 : count;
	assign done = reached;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= '0;
		else
			count <= next_count;
	end

endmodule : rsdc_vlu_counter

// ---- core/rsdc_top.sv ----
// rotor stall detection configuration, decision and fault pin logic
`timescale 1ns/100ps

module rsdc_top
(
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic [rsdc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [rsdc_pkg::DATA_W-1:0] reg_wdata,
	output logic [rsdc_pkg::DATA_W-1:0]      reg_rdata,
	output logic                             reg_rvalid,
	output logic                             reg_wr_refused,
	input  wire logic                        nvm_load,
	input  wire logic                        password_unlocked,
	input  wire logic                        motor_running,
	input  wire logic                        motor_startup,
	input  wire logic                        rotor_synced,
	input  wire logic                        velocity_loop_update,
	input  wire logic                        stall_clear,
	input  wire logic                        external_fault,
	input  wire logic                        invert_enable,
	input  wire logic [15:0]                 vq_estimate,
	input  wire logic [15:0]                 vq_reference,
	input  wire logic [15:0]                 speed_estimate,
	input  wire logic [15:0]                 max_speed,
	input  wire logic [15:0]                 backemf_estimate,
	input  wire logic [15:0]                 backemf_reference,
	output logic                             open_loop_applied,
	output logic [rsdc_pkg::PCT_W-1:0]       forced_open_loop_command,
	output logic [rsdc_pkg::PCT_W-1:0]       forced_open_loop_threshold,
	output logic                             stall_detected,
	output logic                             rotor_sync_timed_out,
	output logic                             password_protected,
	output logic                             fault_output_pin_n
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [rsdc_pkg::CNT_W-1:0] pow2_count
	(
		input logic [4:0] exponent
	);
		pow2_count = rsdc_pkg::CNT_W'(1) << exponent;
	endfunction : pow2_count

	// true when value*2^shift lies below ref*mult
	function automatic logic scaled_below
	(
		input logic [15:0] value,
		input logic [15:0] ref_value,
		input logic [4:0]  mult,
		input logic [3:0]  shift
	);
		logic [31:0] lhs;
		logic [31:0] rhs;
		lhs = 32'(value) << shift;
		rhs = 32'(ref_value) * 32'(mult);
		scaled_below = (lhs < rhs);
	endfunction : scaled_below

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0]                   cfg_shadow;
	logic [31:0]                   thr_shadow;
	logic [31:0]                   cfg_nvm;
	logic [31:0]                   thr_nvm;
	rsdc_pkg::rsdc_state_t         state;
	rsdc_pkg::rsdc_state_t         next_state;

	wire hit_cfg_sh  = (reg_addr == rsdc_pkg::OFS_CFG_SHADOW);
	wire hit_thr_sh  = (reg_addr == rsdc_pkg::OFS_THR_SHADOW);
	wire hit_cfg_nvm = (reg_addr == rsdc_pkg::OFS_CFG_NVM);
	wire hit_thr_nvm = (reg_addr == rsdc_pkg::OFS_THR_NVM);
	wire hit_status  = (reg_addr == rsdc_pkg::OFS_STATUS);

	// ------------------------------------------------------------
	// password protection of stored data
	// ------------------------------------------------------------
	wire [15:0] password = thr_nvm[rsdc_pkg::PASSWORD_LSB +:
		rsdc_pkg::PASSWORD_W];
	wire protect_on = (password != rsdc_pkg::PASSWORD_NONE_LO) &&
		(password != rsdc_pkg::PASSWORD_NONE_HI);
	wire nvm_hit      = hit_cfg_nvm || hit_thr_nvm;
	wire nvm_blocked  = protect_on && !password_unlocked;
	wire nvm_wr_ok    = reg_wr && nvm_hit && !nvm_blocked;
	wire next_refused = reg_wr && nvm_hit && nvm_blocked;

	// ------------------------------------------------------------
	// register write and load paths
	// ------------------------------------------------------------
	// a bus write wins over a load in the same cycle
	wire [31:0] next_cfg_shadow =
		(reg_wr && hit_cfg_sh) ? reg_wdata :
		nvm_load ? cfg_nvm : cfg_shadow;
	wire [31:0] next_thr_shadow =
		(reg_wr && hit_thr_sh) ? reg_wdata :
		nvm_load ? thr_nvm : thr_shadow;
	wire [31:0] next_cfg_nvm =
		(nvm_wr_ok && hit_cfg_nvm) ? reg_wdata :
		cfg_nvm;
	wire [31:0] next_thr_nvm =
		(nvm_wr_ok && hit_thr_nvm) ? reg_wdata :
		thr_nvm;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_shadow <= rsdc_pkg::RESET_VALUE;
			thr_shadow <= rsdc_pkg::RESET_VALUE;
			cfg_nvm    <= rsdc_pkg::RESET_VALUE;
			thr_nvm    <= rsdc_pkg::RESET_VALUE;
		end
		else
		begin
			cfg_shadow <= next_cfg_shadow;
			thr_shadow <= next_thr_shadow;
			cfg_nvm    <= next_cfg_nvm;
			thr_nvm    <= next_thr_nvm;
		end
	end

	// ------------------------------------------------------------
	// field extraction from the shadow copy
	// ------------------------------------------------------------
	wire [6:0] ol_cmd_n   = cfg_shadow[rsdc_pkg::OL_CMD_LSB +:
		rsdc_pkg::OL_CMD_W];
	wire [5:0] ol_th_n    = cfg_shadow[rsdc_pkg::OL_TH_LSB +:
		rsdc_pkg::OL_TH_W];
	wire [3:0] bemf_n     = cfg_shadow[rsdc_pkg::BEMF_TH_LSB +:
		rsdc_pkg::BEMF_TH_W];
	wire [2:0] criteria   = cfg_shadow[rsdc_pkg::CRIT_LSB +:
		rsdc_pkg::CRIT_W];
	wire [1:0] blank_n    = cfg_shadow[rsdc_pkg::BLANK_LSB +:
		rsdc_pkg::BLANK_W];
	wire [3:0] sync_n     = cfg_shadow[rsdc_pkg::SYNC_TOUT_LSB +:
		rsdc_pkg::SYNC_TOUT_W];
	wire       flt_dis    = cfg_shadow[rsdc_pkg::FLT_DIS_BIT];
	wire       flt_st_dis = cfg_shadow[rsdc_pkg::FLT_START_DIS_BIT];
	wire [3:0] det_n      = thr_shadow[rsdc_pkg::DET_TIME_LSB +:
		rsdc_pkg::DET_TIME_W];
	wire [2:0] high_n     = thr_shadow[rsdc_pkg::HIGH_TH_LSB +:
		rsdc_pkg::HIGH_TH_W];
	wire [2:0] low_n      = thr_shadow[rsdc_pkg::LOW_TH_LSB +:
		rsdc_pkg::LOW_TH_W];
	wire [3:0] speed_n    = thr_shadow[rsdc_pkg::SPEED_TH_LSB +:
		rsdc_pkg::SPEED_TH_W];

	// ------------------------------------------------------------
	// forced open-loop command and threshold
	// ------------------------------------------------------------
	wire [16:0] ol_cmd_steps = 17'(ol_cmd_n) + 17'h00001;
	wire [16:0] ol_th_steps  = 17'(ol_th_n) + 17'h00001;
	wire [16:0] ol_cmd_delta = 17'(ol_cmd_steps * rsdc_pkg::OL_CMD_STEP);
	wire [16:0] ol_th_delta  = 17'(ol_th_steps * rsdc_pkg::OL_TH_STEP);
	wire        next_ol_applied = (ol_cmd_n != 7'h00);
	wire [16:0] next_ol_cmd = next_ol_applied ?
		rsdc_pkg::OL_CMD_BASE + ol_cmd_delta : 17'h00000;
	wire [16:0] next_ol_th = invert_enable ?
		rsdc_pkg::OL_TH_BASE - ol_th_delta :
		rsdc_pkg::OL_TH_BASE + ol_th_delta;

	// ------------------------------------------------------------
	// stall criteria
	// ------------------------------------------------------------
	wire [4:0] high_mult  = rsdc_pkg::HIGH_TH_BASE + 5'(high_n);
	wire [4:0] low_mult   = 5'(low_n) + 5'h01;
	wire [4:0] speed_mult = 5'(speed_n) + 5'h01;
	wire [4:0] bemf_mult  = 5'(bemf_n) + 5'h01;

	wire vq_high = !scaled_below(vq_estimate, vq_reference,
		high_mult, 4'(rsdc_pkg::EIGHTH_SHIFT)) &&
		(32'(vq_estimate) << rsdc_pkg::EIGHTH_SHIFT) !=
		32'(vq_reference) * 32'(high_mult);
	wire vq_low = scaled_below(vq_estimate, vq_reference, low_mult,
		4'(rsdc_pkg::EIGHTH_SHIFT));
	wire speed_low = scaled_below(speed_estimate, max_speed, speed_mult,
		4'(rsdc_pkg::SPEED_SHIFT));
	wire bemf_low = scaled_below(backemf_estimate, backemf_reference,
		bemf_mult, 4'(rsdc_pkg::BEMF_SHIFT));

	wire detect_enabled = (criteria != 3'h0);
	wire violation =
		(criteria[rsdc_pkg::CRIT_VQ_BIT] && (vq_high || vq_low)) ||
		(criteria[rsdc_pkg::CRIT_FREQ_BIT] && speed_low) ||
		(criteria[rsdc_pkg::CRIT_BEMF_BIT] && bemf_low);

	// ------------------------------------------------------------
	// windows in velocity loop updates
	// ------------------------------------------------------------
	wire [23:0] sync_target  = pow2_count(5'(sync_n) +
		rsdc_pkg::SYNC_EXP_BASE);
	wire [23:0] blank_target = sync_target >> blank_n;
	wire [23:0] det_target   = pow2_count(5'(det_n) +
		rsdc_pkg::DET_EXP_BASE);

	wire blank_done;
	wire sync_done;
	wire det_done;
	wire blank_clear = (state != rsdc_pkg::RSDC_BLANK);
	wire det_clear   = (state != rsdc_pkg::RSDC_MONITOR) ||
		(velocity_loop_update && !violation);
	wire sync_clear  = !motor_running || rotor_synced;

	rsdc_vlu_counter u_blank
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (blank_clear),
		.tick    (velocity_loop_update),
		.target  (blank_target),
		.done    (blank_done)
	);

	rsdc_vlu_counter u_detect
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (det_clear),
		.tick    (velocity_loop_update),
		.target  (det_target),
		.done    (det_done)
	);

	rsdc_vlu_counter u_sync
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (sync_clear),
		.tick    (velocity_loop_update),
		.target  (sync_target),
		.done    (sync_done)
	);

	// ------------------------------------------------------------
	// stall decision sequence
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			rsdc_pkg::RSDC_IDLE:
				if (motor_running && detect_enabled)
					next_state = rsdc_pkg::RSDC_BLANK;
			rsdc_pkg::RSDC_BLANK:
				if (blank_done)
					next_state = rsdc_pkg::RSDC_MONITOR;
			rsdc_pkg::RSDC_MONITOR:
				if (det_done)
					next_state = rsdc_pkg::RSDC_STALLED;
			rsdc_pkg::RSDC_STALLED:
				if (stall_clear)
					next_state = rsdc_pkg::RSDC_IDLE;
		endcase
		if (!motor_running || !detect_enabled)
			next_state = rsdc_pkg::RSDC_IDLE;
	end

	wire next_stall   = (next_state == rsdc_pkg::RSDC_STALLED);
	wire next_sync_to = motor_running && !rotor_synced && sync_done;
	wire fault_event  = next_stall || next_sync_to || external_fault;
	wire next_pin_n   = !((fault_event && !flt_dis) ||
		(motor_startup && !flt_st_dis));

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	wire [31:0] status_word = {26'h0000000, protect_on,
		rotor_sync_timed_out, stall_detected,
		1'b0, state};
	wire [31:0] next_rdata = !reg_rd ? reg_rdata :
		hit_cfg_sh  ? cfg_shadow :
		hit_thr_sh  ? thr_shadow :
		hit_cfg_nvm ? cfg_nvm :
		hit_thr_nvm ? thr_nvm :
		hit_status  ? status_word : 32'h0000_0000;

	// ------------------------------------------------------------
	// output and state flops
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= rsdc_pkg::RSDC_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata      <= 32'h0000_0000;
			reg_rvalid     <= 1'b0;
			reg_wr_refused <= 1'b0;
		end
		else
		begin
			reg_rdata      <= next_rdata;
			reg_rvalid     <= reg_rd;
			reg_wr_refused <= next_refused;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			open_loop_applied          <= 1'b0;
			forced_open_loop_command   <= 17'h00000;
			forced_open_loop_threshold <= 17'h00000;
			stall_detected             <= 1'b0;
			rotor_sync_timed_out       <= 1'b0;
			password_protected         <= 1'b0;
			fault_output_pin_n         <= 1'b1;
		end
		else
		begin
			open_loop_applied          <= next_ol_applied;
			forced_open_loop_command   <= next_ol_cmd;
			forced_open_loop_threshold <= next_ol_th;
			stall_detected             <= next_stall;
			rotor_sync_timed_out       <= next_sync_to;
			password_protected         <= protect_on;
			fault_output_pin_n         <= next_pin_n;
		end
	end

endmodule : rsdc_top

// ---- sim/rsdc_motor_model.sv ----
// motor side model: loop update pulses and estimates
`timescale 1ns/100ps
module rsdc_motor_model
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  viol,
	output logic             vlu,
	output logic [15:0]      vq_est,
	output logic [15:0]      vq_ref,
	output logic [15:0]      spd_est,
	output logic [15:0]      spd_max,
	output logic [15:0]      bemf_est,
	output logic [15:0]      bemf_ref
);
	logic [1:0] div;

	// one loop update every four clocks
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			div <= 2'h0;
		else
			div <= div + 2'h1;

	assign vlu      = (div == 2'h3);
	assign vq_ref   = 16'h0100;
	assign spd_max  = 16'h1000;
	assign bemf_ref = 16'h0100;
	// a stalled rotor shows zero on each violated estimate
	assign vq_est   = viol[0] ? 16'h0000 : 16'h0100;
	assign spd_est  = viol[1] ? 16'h0000 : 16'h1000;
	assign bemf_est = viol[2] ? 16'h0000 : 16'h0100;
endmodule : rsdc_motor_model

// ---- sim/rsdc_checker.sv ----
// port level assertions for the stall detection block
`timescale 1ns/100ps
module rsdc_checker
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        reg_rvalid,
	input  wire logic        reg_wr_refused,
	input  wire logic        password_unlocked,
	input  wire logic        password_protected,
	input  wire logic        motor_running,
	input  wire logic        motor_startup,
	input  wire logic        rotor_synced,
	input  wire logic        velocity_loop_update,
	input  wire logic        stall_clear,
	input  wire logic        external_fault,
	input  wire logic        invert_enable,
	input  wire logic        open_loop_applied,
	input  wire logic [16:0] forced_open_loop_command,
	input  wire logic [16:0] forced_open_loop_threshold,
	input  wire logic        stall_detected,
	input  wire logic        rotor_sync_timed_out,
	input  wire logic        fault_output_pin_n
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe got no answer");
	a_cmd_off: assert property (!open_loop_applied |->
		forced_open_loop_command == 17'h00000)
		else $error("command present while not applied");
	a_cmd_on: assert property (open_loop_applied |->
		forced_open_loop_command >= 17'h068B0 &&
		forced_open_loop_command <= 17'h19000)
		else $error("applied command out of range");
	a_thr_plus: assert property ($past(rst_n, 2) &&
		!$past(invert_enable) && !$past(invert_enable, 2) |->
		forced_open_loop_threshold > 17'h0C800)
		else $error("threshold not above half scale");
	a_thr_minus: assert property ($past(rst_n, 2) &&
		$past(invert_enable) && $past(invert_enable, 2) |->
		forced_open_loop_threshold < 17'h0C800)
		else $error("inverted threshold not below half scale");
	a_refuse_cause: assert property (reg_wr_refused |->
		$past(reg_wr && !password_unlocked && password_protected &&
		(reg_addr == 12'h4CD || reg_addr == 12'h4CE)))
		else $error("refusal without protected nvm write");
	a_stall_cause: assert property ($rose(stall_detected) |->
		$past(motor_running) && $past(velocity_loop_update, 2))
		else $error("stall raised without running update");
	a_stall_clear: assert property (stall_clear |=>
		!stall_detected)
		else $error("stall held after clear");
	a_sync_cause: assert property ($rose(rotor_sync_timed_out) |->
		$past(motor_running) && !$past(rotor_synced))
		else $error("sync timeout without unsynced run");
	a_pin_quiet: assert property (!stall_detected &&
		!rotor_sync_timed_out &&
		$past(!external_fault && !motor_startup)
		|-> fault_output_pin_n)
		else $error("fault pin low with no cause");
endmodule : rsdc_checker

// ---- sim/tb_top.sv ----
// testbench for the rotor stall detection block
`timescale 1ns/100ps
module tb_top;
	logic        ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, reg_wr_refused;
	logic        nvm_load, password_unlocked, motor_running, motor_startup;
	logic        rotor_synced, stall_clear, external_fault, invert_enable;
	logic        vlu, open_loop_applied, stall_detected;
	logic        rotor_sync_timed_out, password_protected, fault_output_pin_n;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0]  viol;
	logic [15:0] vq_est, vq_ref, spd_est, spd_max, bemf_est, bemf_ref;
	logic [16:0] cmd, thr;
	int          bad_count, n_compared;

	rsdc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_wr_refused(reg_wr_refused), .nvm_load(nvm_load),
		.password_unlocked(password_unlocked), .motor_running(motor_running),
		.motor_startup(motor_startup), .rotor_synced(rotor_synced),
		.velocity_loop_update(vlu), .stall_clear(stall_clear),
		.external_fault(external_fault), .invert_enable(invert_enable),
		.vq_estimate(vq_est), .vq_reference(vq_ref),
		.speed_estimate(spd_est), .max_speed(spd_max),
		.backemf_estimate(bemf_est), .backemf_reference(bemf_ref),
		.open_loop_applied(open_loop_applied),
		.forced_open_loop_command(cmd), .forced_open_loop_threshold(thr),
		.stall_detected(stall_detected),
		.rotor_sync_timed_out(rotor_sync_timed_out),
		.password_protected(password_protected),
		.fault_output_pin_n(fault_output_pin_n));

	rsdc_motor_model motor (.ref_clk(ref_clk), .rst_n(rst_n), .viol(viol),
		.vlu(vlu), .vq_est(vq_est), .vq_ref(vq_ref), .spd_est(spd_est),
		.spd_max(spd_max), .bemf_est(bemf_est), .bemf_ref(bemf_ref));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	task tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task rd_chk(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1;
		chk({31'h0, reg_rvalid}, 32'h1);
		chk(reg_rdata, e);
	endtask : rd_chk

	task settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle

	// counts update pulses until the flag rises, -1 if it never does
	task run_upd(input bit sync, input int lim, output int cnt);
		cnt = 0;
		repeat (lim * 4)
		begin
			@(posedge ref_clk);
			#1;
			if (sync ? rotor_sync_timed_out : stall_detected)
				return;
			if (vlu)
				cnt++;
		end
		cnt = -1;
	endtask : run_upd

	task expect_at(input bit sync, input int lo, input int hi);
		int c;
		run_upd(sync, hi + 8, c);
		chk({31'h0, c >= lo && c <= hi}, 32'h1);
		if (c < 0)
			tally_and_finish();
	endtask : expect_at

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		rd_chk(rsdc_pkg::OFS_CFG_SHADOW, 32'h0);
		rd_chk(rsdc_pkg::OFS_THR_SHADOW, 32'h0);
		rd_chk(rsdc_pkg::OFS_CFG_NVM, 32'h0);
		rd_chk(rsdc_pkg::OFS_THR_NVM, 32'h0);
		wr(12'h000, 32'hFFFF_FFFF);
		rd_chk(12'h000, 32'h0);
		chk({15'h0, thr}, 32'h0000_CB20);
		chk({31'h0, open_loop_applied}, 32'h0);
		chk({31'h0, password_protected}, 32'h0);
	endtask : t_reset

	task t_open_loop;
		logic [31:0] w;
		for (int n = 1; n < 128; n += 126)
		begin
			w = (n << 4) | ((n / 2) << 11);
			wr(rsdc_pkg::OFS_CFG_SHADOW, w);
			settle(2);
			chk({15'h0, cmd}, 32'(25600 + 600 * (n + 1)));
			chk({15'h0, thr}, 32'(51200 + 800 * (n / 2 + 1)));
			@(posedge ref_clk) invert_enable <= 1'b1;
			settle(3);
			chk({15'h0, thr}, 32'(51200 - 800 * (n / 2 + 1)));
			@(posedge ref_clk) invert_enable <= 1'b0;
			rd_chk(rsdc_pkg::OFS_CFG_SHADOW, w);
		end
		wr(rsdc_pkg::OFS_CFG_SHADOW, 32'h0);
		settle(2);
		chk({15'h0, cmd}, 32'h0);
		chk({31'h0, open_loop_applied}, 32'h0);
	endtask : t_open_loop

	task t_nvm_copy;
		wr(rsdc_pkg::OFS_CFG_NVM, 32'hC3A5_5A30);
		@(posedge ref_clk) nvm_load <= 1'b1;
		@(posedge ref_clk) nvm_load <= 1'b0;
		rd_chk(rsdc_pkg::OFS_CFG_SHADOW, 32'hC3A5_5A30);
	endtask : t_nvm_copy

	task t_criteria;
		int c;
		// blanking N=3 over sync N=0 gives 32, detection N=0 gives 64
		for (int b = 0; b < 4; b++)
		begin
			wr(rsdc_pkg::OFS_CFG_SHADOW, 32'h0300_0000 |
				(b < 3 ? 32'h1 << (21 + b) : 32'h0));
			@(posedge ref_clk);
			viol          <= (b == 3) ? 3'h7 : 3'(1 << ((b + 1) % 3));
			motor_running <= 1'b1;
			run_upd(0, 200, c);
			chk({31'h0, c < 0}, 32'h1);
			@(posedge ref_clk) motor_running <= 1'b0;
			if (b == 3)
				break;
			@(posedge ref_clk);
			viol          <= 3'(1 << b);
			motor_running <= 1'b1;
			expect_at(0, 96, 98);
			settle(2);
			chk({31'h0, fault_output_pin_n}, 32'h0);
			rd_chk(rsdc_pkg::OFS_STATUS, 32'h0000_000B);
			wr(rsdc_pkg::OFS_CFG_SHADOW, 32'h4300_0000 | (1 << (21 + b)));
			settle(2);
			chk({31'h0, fault_output_pin_n}, 32'h1);
			@(posedge ref_clk) stall_clear <= 1'b1;
			@(posedge ref_clk) stall_clear <= 1'b0;
			motor_running <= 1'b0;
			settle(1);
			chk({31'h0, stall_detected}, 32'h0);
		end
	endtask : t_criteria

	task t_pins;
		wr(rsdc_pkg::OFS_CFG_SHADOW, 32'h0);
		@(posedge ref_clk) motor_startup <= 1'b1;
		settle(3);
		chk({31'h0, fault_output_pin_n}, 32'h0);
		wr(rsdc_pkg::OFS_CFG_SHADOW, 32'h8000_0000);
		settle(3);
		chk({31'h0, fault_output_pin_n}, 32'h1);
		@(posedge ref_clk) motor_startup <= 1'b0;
		wr(rsdc_pkg::OFS_CFG_SHADOW, 32'h0);
		// start on an update edge so both sides count the same first one
		repeat (4) if (!vlu) @(posedge ref_clk);
		rotor_synced  <= 1'b0;
		motor_running <= 1'b1;
		expect_at(1, 256, 258);
		settle(2);
		chk({31'h0, fault_output_pin_n}, 32'h0);
		@(posedge ref_clk) motor_running <= 1'b0;
	endtask : t_pins

	task t_password;
		wr(rsdc_pkg::OFS_THR_NVM, 32'hFFFF_0000);
		settle(3);
		chk({31'h0, password_protected}, 32'h0);
		wr(rsdc_pkg::OFS_THR_NVM, 32'h1234_0000);
		settle(3);
		chk({31'h0, password_protected}, 32'h1);
		wr(rsdc_pkg::OFS_THR_NVM, 32'h0);
		settle(0);
		chk({31'h0, reg_wr_refused}, 32'h1);
		rd_chk(rsdc_pkg::OFS_THR_NVM, 32'h1234_0000);
		@(posedge ref_clk) password_unlocked <= 1'b1;
		wr(rsdc_pkg::OFS_THR_NVM, 32'h0);
		settle(3);
		chk({31'h0, password_protected}, 32'h0);
	endtask : t_password

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial
	begin
		{rst_n, reg_wr, reg_rd, nvm_load, password_unlocked} = 5'h0;
		{motor_running, motor_startup, stall_clear} = 3'h0;
		{external_fault, invert_enable, viol} = 5'h0;
		rotor_synced = 1'b1;
		reg_addr     = 12'h000;
		reg_wdata    = 32'h0;
		bad_count    = 0;
		n_compared   = 0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_open_loop();
		t_nvm_copy();
		t_criteria();
		t_pins();
		t_password();
		tally_and_finish();
	end
endmodule : tb_top

bind rsdc_top rsdc_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rvalid(reg_rvalid), .reg_wr_refused(reg_wr_refused),
	.password_unlocked(password_unlocked),
	.password_protected(password_protected), .motor_running(motor_running),
	.motor_startup(motor_startup), .rotor_synced(rotor_synced),
	.velocity_loop_update(velocity_loop_update), .stall_clear(stall_clear),
	.external_fault(external_fault), .invert_enable(invert_enable),
	.open_loop_applied(open_loop_applied),
	.forced_open_loop_command(forced_open_loop_command),
	.forced_open_loop_threshold(forced_open_loop_threshold),
	.stall_detected(stall_detected),
	.rotor_sync_timed_out(rotor_sync_timed_out),
	.fault_output_pin_n(fault_output_pin_n));
